/* File: rtl/mii_rx_pkg.sv */
// Package with constants and carrier types for the receive and status port.
package mii_rx_pkg;
  // Register port offsets (word addresses on the plain register port).
  localparam logic [7:0] SELF_STATUS_OFS = 8'h19;
  localparam logic [7:0] LOOPBACK_BYPASS_OFS = 8'h18;
  localparam logic [7:0] LOW_SPEED_STATUS_OFS = 8'h1B;
  localparam logic [7:0] INTERRUPT_MASK_OFS = 8'h10;
  localparam logic [7:0] INTERRUPT_STATUS_OFS = 8'h11;
  localparam logic [7:0] MODE_CTRL_OFS = 8'h20;
  // Field positions.
  localparam int PHY_ADDR_LSB = 0;
  localparam int CODER_BYPASS_BIT = 14;
  localparam int ALIGN_BYPASS_BIT = 12;
  localparam int SERIAL_SELECT_BIT = 9;
  localparam int MODE_FAST_BIT = 0;
  localparam int MODE_FULL_DUPLEX_BIT = 1;
  // Reset values.
  localparam logic [15:0] MODE_CTRL_RST = 16'h0001;
  localparam logic [15:0] INTERRUPT_MASK_RST = 16'h0000;
  // Receive clock dividers, counted in link clock cycles per half period.
  localparam int LINK_CLK_MHZ = 50;
  localparam int RX_CLK_FAST_MHZ_X10 = 250;
  localparam int RX_CLK_NIBBLE_MHZ_X10 = 25;
  localparam int RX_CLK_SERIAL_MHZ_X10 = 100;
  localparam logic [4:0] HALF_FAST = 5'((LINK_CLK_MHZ * 10) / (2 * RX_CLK_FAST_MHZ_X10));
  localparam logic [4:0] HALF_NIBBLE = 5'((LINK_CLK_MHZ * 10) / (2 * RX_CLK_NIBBLE_MHZ_X10));
  localparam logic [4:0] HALF_SERIAL = 5'((LINK_CLK_MHZ * 10) / (2 * RX_CLK_SERIAL_MHZ_X10));
  // False carrier pattern on the receive data outputs.
  localparam logic [3:0] FALSE_CARRIER_CODE = 4'hE;
  // Straps sampled once reset is released.
  typedef struct packed {
    logic [4:0] phy_addr;
    logic output_drive_strength_select;
    logic block_coder_bypass;
    logic symbol_alignment_bypass;
    logic low_speed_serial_select;
  } strap_t;
  // One received symbol from the receive datapath.
  typedef struct packed {
    logic valid;
    logic error;
    logic false_carrier;
    logic [4:0] code;
  } rx_sym_t;
  // Pins driven towards the controller.
  typedef struct packed {
    logic [3:0] rxd;
    logic dv;
    logic er;
    logic clk;
  } mii_rx_pins_t;
endpackage

/* File: rtl/level_sync.sv */
`timescale 1ns/1ns
// Three-stage level synchroniser with agreement filter.
module level_sync
  import mii_rx_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // A change is taken only once stages two and three agree.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_o <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          q_o[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

/* File: rtl/mii_rx_status_port.sv */
`timescale 1ns/1ns
// Receive and status side of the controller-facing port of the transceiver.
module mii_rx_status_port
  import mii_rx_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic link_clk_i,
  input wire logic link_srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [8:0] strap_pins_i,
  input wire logic repeater_mode_i,
  input wire logic receive_enable_i,
  input wire logic collision_i,
  input wire logic sqe_i,
  input wire logic rx_activity_i,
  input wire logic tx_activity_i,
  input wire logic [7:0] int_event_i,
  input wire rx_sym_t rx_sym_i,
  output mii_rx_pins_t rx_pins_o,
  output logic [3:0] rxd_oe_o,
  output logic dv_oe_o,
  output logic er_oe_o,
  output logic rx_clk_oe_o,
  output logic col_o,
  output logic col_oe_o,
  output logic crs_o,
  output logic crs_oe_o,
  output logic drive_strength_o,
  output logic irq_n_o
);
  // Strap order on strap_pins_i: [4:0] address, 5 drive, 6 coder, 7 align, 8 serial.
  strap_t strap_r;
  logic strap_done_r;
  logic [15:0] mode_ctrl_r;
  logic [15:0] int_mask_r;
  logic [15:0] int_status_r;
  logic [7:0] int_event_d_r;
  logic coder_bypass_r;
  logic align_bypass_r;
  logic serial_sel_r;
  logic irq_n_r;
  logic [5:0] sys_ctrl;
  logic [5:0] link_ctrl;
  logic [2:0] pin_sync;
  logic [7:0] event_sync;
  logic receive_enable_s;
  logic repeater_s;
  logic collision_s;
  logic sqe_s;
  logic rx_act_s;
  logic tx_act_s;
  logic half_duplex;
  logic fast;
  logic [15:0] change;

  // The repeater, receive enable and transmit activity pins pass the filtered three-stage synchroniser.
  // These pins come from other boards or from the analog front end and have no fixed phase.
  // Three stages cost a few cycles of latency. In return, a glitch shorter than one cycle
  // never reaches the status logic.
  level_sync #(.WIDTH(3)) u_pin_sync (
    .clk_i(sys_clk_i),
    .srst_i(srst_i),
    .d_i({repeater_mode_i, receive_enable_i, tx_activity_i}),
    .q_o(pin_sync)
  );
  assign repeater_s = pin_sync[2];
  assign receive_enable_s = pin_sync[1];
  assign tx_act_s = pin_sync[0];

  // Medium status and interrupt events come from the analog side, also asynchronous.
  // Each bit is filtered on its own, so bits of one event word may land a cycle apart.
  // That is harmless here because every event bit only marks its own status flag; the medium bits only drive output levels.
  // Collision and carrier therefore lag the medium by the same few cycles.
  level_sync #(.WIDTH(11)) u_evt_sync (
    .clk_i(sys_clk_i),
    .srst_i(srst_i),
    .d_i({collision_i, sqe_i, rx_activity_i, int_event_i}),
    .q_o({collision_s, sqe_s, rx_act_s, event_sync})
  );

  // Straps are caught on the first clock after reset release, before drivers turn on.
  // The shared pins still float on their resistors at that edge, because every enable is low.
  // Each field is taken from its own pin, so the order of the struct members does not matter.
  // A strap that changes later has no effect until the next reset.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      strap_r <= '0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_r.phy_addr <= strap_pins_i[4:0];
      strap_r.output_drive_strength_select <= strap_pins_i[5];
      strap_r.block_coder_bypass <= strap_pins_i[6];
      strap_r.symbol_alignment_bypass <= strap_pins_i[7];
      strap_r.low_speed_serial_select <= strap_pins_i[8];
      strap_done_r <= 1'b1;
    end
  end

  // Bypass and serial bits load from the straps, then follow software writes.
  // No write is taken while the straps are being sampled. Software requests are only
  // accepted from the edge after that, so the strap value cannot be lost.
  // Only the named bit of each register is stored; the other bits read back as zero.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      coder_bypass_r <= 1'b0;
      align_bypass_r <= 1'b0;
      serial_sel_r <= 1'b0;
    end else if (!strap_done_r) begin
      coder_bypass_r <= strap_pins_i[6];
      align_bypass_r <= strap_pins_i[7];
      serial_sel_r <= strap_pins_i[8];
    end else if (reg_wr_i) begin
      if (reg_addr_i == LOOPBACK_BYPASS_OFS) begin
        coder_bypass_r <= reg_wdata_i[CODER_BYPASS_BIT];
        align_bypass_r <= reg_wdata_i[ALIGN_BYPASS_BIT];
      end
      if (reg_addr_i == LOW_SPEED_STATUS_OFS) begin
        serial_sel_r <= reg_wdata_i[SERIAL_SELECT_BIT];
      end
    end
  end

  // Mode and mask registers written by software.
  // Mode control keeps the whole word, but only the speed and duplex bits are decoded.
  // The mask has a bit for each event. Bits that have no event are kept but never used.
  // An unmapped write matches neither address and is dropped.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mode_ctrl_r <= MODE_CTRL_RST;
      int_mask_r <= INTERRUPT_MASK_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == MODE_CTRL_OFS) begin
        mode_ctrl_r <= reg_wdata_i;
      end
      if (reg_addr_i == INTERRUPT_MASK_OFS) begin
        int_mask_r <= reg_wdata_i;
      end
    end
  end

  assign fast = mode_ctrl_r[MODE_FAST_BIT];
  assign half_duplex = !mode_ctrl_r[MODE_FULL_DUPLEX_BIT];
  assign change = {8'h00, event_sync ^ int_event_d_r};

  // Status bits latch changes; a new change wins over the clearing read.
  // Both edges of an event count as a change, so a short pulse leaves two marks.
  // If a change arrives in the same cycle as the read, it is kept rather than lost.
  // An unmasked change also pulls the interrupt line low in that case, so software sees the new event.
  // A masked change sets its status bit but does not move the interrupt line.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      int_event_d_r <= '0;
      int_status_r <= '0;
      irq_n_r <= 1'b1;
    end else begin
      int_event_d_r <= event_sync;
      if (reg_rd_i && reg_addr_i == INTERRUPT_STATUS_OFS) begin
        int_status_r <= change;
      end else begin
        int_status_r <= int_status_r | change;
      end
      if (|(change & int_mask_r)) begin
        irq_n_r <= 1'b0;
      end else if (reg_rd_i && reg_addr_i == INTERRUPT_STATUS_OFS) begin
        irq_n_r <= 1'b1;
      end
    end
  end

  // Read data stands in the cycle after the read strobe; unmapped reads return zero.
  // The bus returns to zero in every other cycle, so it never shows a stale value.
  // Reading the status word also clears it, as handled in the status process above.
  // The slave never inserts wait states.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        SELF_STATUS_OFS: reg_rdata_o <= {11'h000, strap_r.phy_addr};
        LOOPBACK_BYPASS_OFS: reg_rdata_o <= 16'((32'(coder_bypass_r) << CODER_BYPASS_BIT) |
          (32'(align_bypass_r) << ALIGN_BYPASS_BIT));
        LOW_SPEED_STATUS_OFS: reg_rdata_o <= 16'(32'(serial_sel_r) << SERIAL_SELECT_BIT);
        INTERRUPT_MASK_OFS: reg_rdata_o <= int_mask_r;
        INTERRUPT_STATUS_OFS: reg_rdata_o <= int_status_r;
        MODE_CTRL_OFS: reg_rdata_o <= mode_ctrl_r;
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // Collision, carrier sense and their enables run on the system clock.
  // In full duplex, collision is held low. A controller must ignore it there anyway,
  // and a quiet line is easier to debug.
  // Quality error only shows at the lower speed, where the medium reports it.
  // The enables rise one edge after the straps are captured.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      col_o <= 1'b0;
      crs_o <= 1'b0;
      col_oe_o <= 1'b0;
      crs_oe_o <= 1'b0;
      drive_strength_o <= 1'b0;
      irq_n_o <= 1'b1;
    end else begin
      col_o <= half_duplex && (collision_s || (!fast && sqe_s));
      if (repeater_s || !half_duplex) begin
        crs_o <= rx_act_s;
      end else begin
        crs_o <= rx_act_s || tx_act_s;
      end
      col_oe_o <= strap_done_r;
      crs_oe_o <= strap_done_r;
      drive_strength_o <= strap_r.output_drive_strength_select;
      irq_n_o <= irq_n_r;
    end
  end

  // Controls cross to the link domain as slow levels through the synchroniser.
  // These bits change only on a strap load, a software write or the receive enable pin, so a level crossing is enough.
  // During a mode change, one receive clock period may be odd.
  // The link side is steady again within a few link cycles.
  // The management clock is not used here, so its rate and phase cannot affect this logic.
  assign sys_ctrl = {strap_done_r && receive_enable_s, fast, serial_sel_r,
    coder_bypass_r, align_bypass_r, 1'b0};
  level_sync #(.WIDTH(6)) u_ctrl_sync (
    .clk_i(link_clk_i),
    .srst_i(link_srst_i),
    .d_i(sys_ctrl),
    .q_o(link_ctrl)
  );

  // Link-side copies of the controls. From here down, only the link clock is used.
  // Nothing below reads a system-clock register directly.
  logic l_en;
  logic l_fast;
  logic l_serial;
  logic l_coder_bp;
  logic l_align_bp;
  logic [4:0] div_r;
  logic rclk_r;
  logic [4:0] half;
  assign l_en = link_ctrl[5];
  assign l_fast = link_ctrl[4];
  assign l_serial = link_ctrl[3];
  assign l_coder_bp = link_ctrl[2];
  assign l_align_bp = link_ctrl[1];
  assign half = l_fast ? HALF_FAST : (l_serial ? HALF_SERIAL : HALF_NIBBLE);

  // Free-running receive clock divider; it never stops while the link clock runs.
  // The half period comes from the synchronised speed and serial bits.
  // A divider ratio that is not a whole number rounds down, so a slow link clock
  // gives a slightly fast receive clock.
  always_ff @(posedge link_clk_i) begin
    if (link_srst_i) begin
      div_r <= '0;
      rclk_r <= 1'b0;
    end else if (div_r + 5'd1 >= half) begin
      div_r <= '0;
      rclk_r <= !rclk_r;
    end else begin
      div_r <= div_r + 5'd1;
    end
  end

  // Data changes on the falling receive clock edge so the controller samples it stable.
  // The pin clock is registered from the next divider value. It therefore falls on the
  // same link edge that launches new data, and never rises while data moves.
  // This holds even at the fastest rate, where the divider toggles on every edge.
  logic launch;
  logic rclk_next;
  assign launch = rclk_r && (div_r + 5'd1 >= half);
  assign rclk_next = (div_r + 5'd1 >= half) ? !rclk_r : rclk_r;
  logic [4:0] code_sr_r;

  // Receive pins and their enables. The output mode is chosen only at a launch point,
  // so a mode change never splits a nibble. The enables follow the receive enable pin,
  // so several transceivers can share one bus.
  always_ff @(posedge link_clk_i) begin
    if (link_srst_i) begin
      rx_pins_o <= '0;
      code_sr_r <= '0;
      rxd_oe_o <= '0;
      dv_oe_o <= 1'b0;
      er_oe_o <= 1'b0;
      rx_clk_oe_o <= 1'b0;
    end else begin
      rx_pins_o.clk <= rclk_next;
      rxd_oe_o <= {4{l_en}};
      dv_oe_o <= l_en;
      er_oe_o <= l_en;
      rx_clk_oe_o <= l_en;
      if (launch) begin
        if (l_align_bp) begin
          rx_pins_o.dv <= 1'b1;
          rx_pins_o.rxd <= rx_sym_i.code[3:0];
          rx_pins_o.er <= rx_sym_i.code[4];
        end else if (l_coder_bp && l_fast) begin
          rx_pins_o.dv <= rx_sym_i.valid;
          rx_pins_o.rxd <= rx_sym_i.valid ? rx_sym_i.code[3:0] : 4'h0;
          rx_pins_o.er <= rx_sym_i.valid && rx_sym_i.code[4];
        end else if (rx_sym_i.false_carrier && !rx_sym_i.valid) begin
          rx_pins_o.dv <= 1'b0;
          rx_pins_o.rxd <= FALSE_CARRIER_CODE;
          rx_pins_o.er <= 1'b1;
        end else if (!l_fast && l_serial) begin
          code_sr_r <= rx_sym_i.code;
          rx_pins_o.dv <= rx_sym_i.valid;
          rx_pins_o.rxd <= {3'b000, rx_sym_i.valid & rx_sym_i.code[0]};
          rx_pins_o.er <= 1'b0;
        end else begin
          rx_pins_o.dv <= rx_sym_i.valid;
          rx_pins_o.rxd <= rx_sym_i.valid ? rx_sym_i.code[3:0] : 4'h0;
          rx_pins_o.er <= rx_sym_i.valid && rx_sym_i.error;
        end
      end
    end
  end
endmodule

/* File: sim/mii_rx_status_port_properties.sv */
// Concurrent checks on the ports of the receive and status port.
`timescale 1ns/1ns
module mii_rx_status_port_properties
  import mii_rx_pkg::*;
(
  input wire logic sys_clk_i, srst_i, reg_wr_i, reg_rd_i, repeater_mode_i, receive_enable_i,
  input wire logic collision_i, sqe_i, rx_activity_i, tx_activity_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] int_event_i,
  input wire logic [3:0] rxd_oe_o,
  input wire logic dv_oe_o, er_oe_o, rx_clk_oe_o, col_o, crs_o, drive_strength_o, irq_n_o
);
  logic [11:0] col_h, act_h, rx_h, rep_h, ev_h;
  logic [2:0] rd_h;
  logic [7:0] ev_q;
  // Histories span the input synchronisers, so an output may lag its cause.
  always_ff @(posedge sys_clk_i) begin
    ev_q <= int_event_i;
    if (srst_i) begin
      {col_h, act_h, rx_h, rep_h, ev_h, rd_h} <= '0;
    end else begin
      col_h <= {col_h[10:0], collision_i | sqe_i};
      act_h <= {act_h[10:0], rx_activity_i | tx_activity_i};
      rx_h <= {rx_h[10:0], rx_activity_i};
      rep_h <= {rep_h[10:0], repeater_mode_i};
      ev_h <= {ev_h[10:0], (ev_q != int_event_i) || (reg_wr_i && reg_addr_i == INTERRUPT_MASK_OFS)};
      rd_h <= {rd_h[1:0], reg_rd_i && reg_addr_i == INTERRUPT_STATUS_OFS};
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  property p_col; col_o |-> |col_h; endproperty
  a_col: assert property (p_col) else $error("collision without cause");
  property p_crs; crs_o |-> |act_h; endproperty
  a_crs: assert property (p_crs) else $error("carrier without activity");
  property p_crs_rep; &rep_h && crs_o |-> |rx_h; endproperty
  a_crs_rep: assert property (p_crs_rep) else $error("carrier from transmit");
  property p_irq_fall; $fell(irq_n_o) |-> |ev_h; endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt without event");
  property p_irq_rise; $rose(irq_n_o) |-> |rd_h; endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt released early");
  property p_drv; !$past(srst_i) && !$past(srst_i, 2) && !$past(srst_i, 3) |-> $stable(drive_strength_o); endproperty
  a_drv: assert property (p_drv) else $error("drive strength moved");
  property p_off; $fell(receive_enable_i) |-> ##[1:40] ({rxd_oe_o, dv_oe_o, er_oe_o, rx_clk_oe_o} == 7'h00); endproperty
  a_off: assert property (p_off) else $error("receive outputs kept");
  property p_on; $rose(receive_enable_i) |-> ##[1:40] ({rxd_oe_o, dv_oe_o, er_oe_o, rx_clk_oe_o} == 7'h7F); endproperty
  a_on: assert property (p_on) else $error("receive outputs not driven");
  c_irq: cover property ($fell(irq_n_o));
  c_col: cover property ($rose(col_o));
  c_off: cover property ($fell(rx_clk_oe_o));
endmodule
bind mii_rx_status_port mii_rx_status_port_properties u_props (.*);

/* File: sim/mii_mac_rx_model.sv */
// Behavioural receiving controller that samples the receive pins.
`timescale 1ns/1ns
module mii_mac_rx_model
  import mii_rx_pkg::*;
(
  input wire logic link_clk_i,
  input wire mii_rx_pins_t pins_i,
  input wire logic clk_oe_i
);
  mii_rx_pins_t seen;
  logic clk_q = 1'b0;
  int cnt = 0;
  int period = 0;
  int caps = 0;
  // Oversampling the receive clock keeps capture clear of its launch edge.
  always @(posedge link_clk_i) begin
    clk_q <= pins_i.clk;
    cnt <= cnt + 1;
    if (clk_oe_i && pins_i.clk && !clk_q) begin
      seen <= pins_i;
      period <= cnt + 1;
      cnt <= 0;
      caps <= caps + 1;
    end
  end
endmodule

/* File: sim/mii_rx_status_port_tb_top.sv */
// Self-checking bench for the receive and status port.
`timescale 1ns/1ns
module mii_rx_status_port_tb_top
  import mii_rx_pkg::*;
;
  logic sys_clk_i = 1'b0, link_clk_i = 1'b0, srst_i = 1'b1, link_srst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, repeater_mode_i = 1'b0, receive_enable_i = 1'b1;
  logic collision_i = 1'b0, sqe_i = 1'b0, rx_activity_i = 1'b0, tx_activity_i = 1'b0;
  logic [8:0] strap_pins_i = 9'h175;
  logic [7:0] int_event_i = 8'h00;
  rx_sym_t rx_sym_i = '0;
  logic [15:0] reg_rdata_o, q;
  mii_rx_pins_t rx_pins_o;
  logic [3:0] rxd_oe_o;
  logic dv_oe_o, er_oe_o, rx_clk_oe_o, col_o, col_oe_o, crs_o, crs_oe_o, drive_strength_o, irq_n_o;
  logic [8:0] tbl [7] = '{9'h111, 9'h150, 9'h190, 9'h1A1, 9'h10A, 9'h188, 9'h006};
  int miscompares = 0;
  int checked = 0;
  mii_rx_status_port DUT (.*);
  mii_mac_rx_model mac (.link_clk_i(link_clk_i), .pins_i(rx_pins_o), .clk_oe_i(rx_clk_oe_o));
  // The link clock is offset so its edges never meet the system clock.
  always #5 sys_clk_i = ~sys_clk_i;
  initial #2 forever #15 link_clk_i = ~link_clk_i;
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // The extra edge keeps back-to-back writes from driving the strobe twice at once.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    cyc(1);
    reg_wr_i <= 1'b0;
    cyc(1);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    cyc(1);
    reg_rd_i <= 1'b0;
    cyc(1);
    chk(n, reg_rdata_o & m, e);
  endtask
  // Eight captured clocks leave room for the control crossing before the judged nibble.
  task automatic rx(input logic [7:0] s, input logic [5:0] e, input logic [5:0] m, input logic [4:0] h);
    int k;
    rx_sym_i <= rx_sym_t'(s);
    k = mac.caps;
    for (int i = 0; i < 3000 && mac.caps < k + 8; i++) cyc(1);
    if (mac.caps < k + 8) miscompares++;
    chk("rx pins", 16'({mac.seen.rxd, mac.seen.dv, mac.seen.er} & m), 16'(e));
    chk("rx clock", 16'(mac.period), 16'({h, 1'b0}));
  endtask
  task automatic results();
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    results();
  end
  initial begin
    cyc(6);
    srst_i <= 1'b0;
    cyc(1);
    strap_pins_i <= 9'h08A;
    cyc(8);
    link_srst_i <= 1'b0;
    rdchk("phy address", SELF_STATUS_OFS, 16'h001F, 16'h0015);
    chk("drive strength", 16'(drive_strength_o), 16'h0001);
    chk("status drivers", 16'({col_oe_o, crs_oe_o}), 16'h0003);
    rdchk("serial strap", LOW_SPEED_STATUS_OFS, 16'h0200, 16'h0200);
    rdchk("bypass straps", LOOPBACK_BYPASS_OFS, 16'h5000, 16'h4000);
    rdchk("mode reset", MODE_CTRL_OFS, 16'hFFFF, MODE_CTRL_RST);
    wr(8'h7F, 16'hFFFF);
    rdchk("unmapped", 8'h7F, 16'hFFFF, 16'h0000);
    rdchk("mask reset", INTERRUPT_MASK_OFS, 16'hFFFF, INTERRUPT_MASK_RST);
    // Only event 0 is unmasked; event 1 must set status silently.
    wr(INTERRUPT_MASK_OFS, 16'h0001);
    int_event_i <= 8'h02;
    cyc(20);
    chk("masked event", 16'(irq_n_o), 16'h0001);
    int_event_i <= 8'h03;
    cyc(40);
    chk("interrupt held", 16'(irq_n_o), 16'h0000);
    rdchk("interrupt status", INTERRUPT_STATUS_OFS, 16'h00FF, 16'h0003);
    cyc(6);
    chk("interrupt released", 16'(irq_n_o), 16'h0001);
    rdchk("status cleared", INTERRUPT_STATUS_OFS, 16'h00FF, 16'h0000);
    foreach (tbl[i]) begin
      wr(MODE_CTRL_OFS, 16'({tbl[i][7], tbl[i][8]}));
      {repeater_mode_i, rx_activity_i, tx_activity_i, collision_i, sqe_i} <= tbl[i][6:2];
      cyc(20);
      chk("collision and carrier", 16'({col_o, crs_o}), 16'(tbl[i][1:0]));
    end
    {repeater_mode_i, rx_activity_i, tx_activity_i, collision_i, sqe_i} <= 5'h00;
    receive_enable_i <= 1'b0;
    cyc(60);
    chk("outputs released", 16'({rxd_oe_o, dv_oe_o, er_oe_o, rx_clk_oe_o}), 16'h0000);
    receive_enable_i <= 1'b1;
    cyc(60);
    chk("outputs driven", 16'({rxd_oe_o, dv_oe_o, er_oe_o, rx_clk_oe_o}), 16'h007F);
    wr(LOOPBACK_BYPASS_OFS, 16'h0000);
    wr(LOW_SPEED_STATUS_OFS, 16'h0000);
    rx(8'h86, 6'h1A, 6'h3F, HALF_NIBBLE);
    wr(LOW_SPEED_STATUS_OFS, 16'h0200);
    rx(8'h81, 6'h06, 6'h06, HALF_SERIAL);
    wr(LOW_SPEED_STATUS_OFS, 16'h0000);
    wr(MODE_CTRL_OFS, 16'h0001);
    rx(8'h85, 6'h16, 6'h3F, HALF_FAST);
    rx(8'hCA, 6'h2B, 6'h3F, HALF_FAST);
    rx(8'h20, 6'h39, 6'h3F, HALF_FAST);
    wr(LOOPBACK_BYPASS_OFS, 16'h4000);
    rx(8'h96, 6'h1B, 6'h3F, HALF_FAST);
    wr(LOOPBACK_BYPASS_OFS, 16'h1000);
    rx(8'h19, 6'h27, 6'h3F, HALF_FAST);
    results();
  end
endmodule
